// file: rtl/acl_top.sv
// Codec command, status and second-level IRQ status logic of the audio link controller.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
// Operation
// - Valid slot 2 sets fresh; status read clears
// - Slot 2 bits 19:4 give returned value
// - Direction bit drives slot 1 bit 19
// - Address bits go to slot 1 18:12
// - Codec select drives slot 0 bits 1:0
// - Nonzero select zeroes slot 0 bits 14:13
// - Powerdown semaphores are plain storage only
// - Link shutdown clears both ready indications
// - Starting warm reset clears link shutdown
// - Warm reset clears itself when clock resumes
// - Sent command clears command new bit
// - Write without new bit keeps command fields
// - Master IRQ sets bit; own read clears
// - Input rising edge in powerdown sets wakeup bit
// - Slot 12 bit 0 sets codec pin bit
// - Slot 0 bit 15 shows codec ready
module acl_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [acl_pkg::ADDR_W-1:0] addr,
   input wire logic [acl_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [acl_pkg::DATA_W-1:0] rd_data,
   input wire logic [acl_pkg::NUM_MASTERS-1:0] master_irq_event,
   input wire logic ac_bit_clk,
   input wire logic ac_sdata_in,
   output logic ac_sync,
   output logic ac_sdata_out
);
   import acl_pkg::*;

   logic rw_reg;
   logic [6:0] cmd_addr_reg;
   logic [1:0] codec_select_reg;
   logic primary_powerdown_semaphore_reg;
   logic secondary_powerdown_semaphore_reg;
   logic link_shutdown_reg;
   logic link_warm_reset_reg;
   logic cmd_new_reg;
   logic [15:0] cmd_data_reg;
   logic status_fresh_flag_reg;
   logic [15:0] returned_register_value_reg;
   logic [7:0] returned_addr_reg;
   logic primary_codec_ready_reg;
   logic secondary_codec_ready_reg;
   logic [NUM_MASTERS-1:0] master_irq_seen_reg;
   logic wakeup_irq_seen_reg;
   logic codec_pin_irq_seen_reg;
   logic [SLOT_W-1:0] slot12_reg;
   logic engine_mode_reg;
   logic [WARM_CNT_W-1:0] warm_cnt_reg;
   logic sdin_d_reg;

   logic bit_clk_s;
   logic sdin_s;
   logic frame_start;
   logic bit_rise;
   logic rx_done;
   acl_rx_frame_type rx;
   acl_tx_frame_type tx;

   // Address decode.
   wire hit_gpio = addr == ADDR_W'({IDX_GPIO_STATUS, BYTE_LANE_ZERO});
   wire hit_status = addr == ADDR_W'({IDX_CODEC_STATUS, BYTE_LANE_ZERO});
   wire hit_ctrl = addr == ADDR_W'({IDX_CODEC_CONTROL, BYTE_LANE_ZERO});
   wire hit_irq = addr == ADDR_W'({IDX_IRQ_STATUS, BYTE_LANE_ZERO});
   wire hit_engine = addr == ADDR_W'({IDX_ENGINE_CONTROL, BYTE_LANE_ZERO});
   wire [NUM_MASTERS-1:0] hit_master;
   wire ctrl_wr = wr_en & hit_ctrl;
   wire ctrl_load = ctrl_wr & wr_data[CTL_NEW];
   wire warm_start = ctrl_wr & wr_data[CTL_WARM] & ~link_warm_reset_reg;
   wire warm_active = link_warm_reset_reg & (warm_cnt_reg != WARM_CNT_W'(WARM_CYCLES));
   wire warm_end = link_warm_reset_reg & ~warm_active & bit_rise;
   wire cmd_go = cmd_new_reg & ~link_warm_reset_reg;
   wire cmd_sent = frame_start & cmd_go;
   wire sel_primary = codec_select_reg == 2'h0;
   wire status_valid = rx_done & rx.tag[TAG_SLOT2];
   wire pin_event = rx_done & rx.tag[TAG_SLOT12] & rx.slot12[GPIO_EVENT_BIT];
   wire wake_event = sdin_s & ~sdin_d_reg & link_shutdown_reg;
   wire shut_next = warm_start ? 1'b0 : ctrl_wr ? wr_data[CTL_SHUTDOWN] : link_shutdown_reg;

   // Per-master decode of the IRQ status registers.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_MASTERS; gi++) begin : g_master
         localparam logic [7:0] IDX_M = IDX_MASTER_STATUS_BASE + 8'(gi) * IDX_MASTER_STRIDE;
         assign hit_master[gi] = addr == ADDR_W'({IDX_M, BYTE_LANE_ZERO});

         // Set wins over the clearing read.
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               master_irq_seen_reg[gi] <= 1'b0;
            end else if (master_irq_event[gi]) begin
               master_irq_seen_reg[gi] <= 1'b1;
            end else if (rd_en & hit_master[gi]) begin
               master_irq_seen_reg[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // Outgoing command frame.
   assign tx.tag = {cmd_go, cmd_go & sel_primary, cmd_go & ~rw_reg & sel_primary,
                    11'h000, codec_select_reg};
   assign tx.slot1 = cmd_go ? {rw_reg, cmd_addr_reg, 12'h000} : '0;
   assign tx.slot2 = (cmd_go & ~rw_reg) ? {cmd_data_reg, 4'h0} : '0;

   // Read data selection; unmapped addresses read as zero.
   wire [DATA_W-1:0] status_word = {returned_addr_reg, primary_codec_ready_reg,
      secondary_codec_ready_reg, 4'h0, status_fresh_flag_reg, 1'b0, returned_register_value_reg};
   wire [DATA_W-1:0] ctrl_word = {rw_reg, cmd_addr_reg, codec_select_reg,
      primary_powerdown_semaphore_reg, secondary_powerdown_semaphore_reg, 1'b0,
      link_shutdown_reg, link_warm_reset_reg, cmd_new_reg, cmd_data_reg};
   wire [DATA_W-1:0] irq_word = {22'h000000, master_irq_seen_reg, wakeup_irq_seen_reg,
      codec_pin_irq_seen_reg};
   wire [DATA_W-1:0] gpio_word = {10'h000, codec_pin_irq_seen_reg, wakeup_irq_seen_reg, slot12_reg};
   wire master_bit = |(hit_master & master_irq_seen_reg);
   wire [DATA_W-1:0] rd_mux = hit_status ? status_word :
                              hit_ctrl ? ctrl_word :
                              hit_irq ? irq_word :
                              hit_gpio ? gpio_word :
                              hit_engine ? {31'h0, engine_mode_reg} :
                              {31'h0, master_bit};

   acl_sync2 #(.WIDTH(2)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in({ac_bit_clk, ac_sdata_in}),
      .sync_out({bit_clk_s, sdin_s})
   );

   acl_frame u_frame (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .bit_clk_s(bit_clk_s),
      .sdin_s(sdin_s),
      .warm_active(warm_active),
      .tx(tx),
      .frame_start(frame_start),
      .bit_rise(bit_rise),
      .rx_done(rx_done),
      .rx(rx),
      .ac_sync(ac_sync),
      .ac_sdata_out(ac_sdata_out)
   );

   // Codec command and control word.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         {rw_reg, cmd_addr_reg, codec_select_reg, primary_powerdown_semaphore_reg,
          secondary_powerdown_semaphore_reg} <= CONTROL_RESET[CTL_RW:CTL_SECONDARY_POWERDOWN_SEMAPHORE];
         cmd_data_reg <= CONTROL_RESET[CTL_DATA_HI:CTL_DATA_LO];
         cmd_new_reg <= 1'b0;
         link_shutdown_reg <= 1'b0;
         engine_mode_reg <= 1'b0;
      end else begin
         if (ctrl_load) begin
            rw_reg <= wr_data[CTL_RW];
            cmd_addr_reg <= wr_data[CTL_ADDR_HI:CTL_ADDR_LO];
            codec_select_reg <= wr_data[CTL_SEL_HI:CTL_SEL_LO];
            cmd_data_reg <= wr_data[CTL_DATA_HI:CTL_DATA_LO];
         end
         if (ctrl_wr) begin
            primary_powerdown_semaphore_reg <= wr_data[CTL_PRIMARY_POWERDOWN_SEMAPHORE];
            secondary_powerdown_semaphore_reg <= wr_data[CTL_SECONDARY_POWERDOWN_SEMAPHORE];
         end
         // A new load wins over the clear of the command just sent.
         cmd_new_reg <= ctrl_load | (cmd_new_reg & ~cmd_sent);
         link_shutdown_reg <= shut_next;
         if (wr_en & hit_engine) begin
            engine_mode_reg <= wr_data[0];
         end
      end
   end

   // Warm reset: sync is held high for a fixed time, then the bit clock is awaited.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         link_warm_reset_reg <= 1'b0;
         warm_cnt_reg <= '0;
      end else begin
         if (warm_start) begin
            link_warm_reset_reg <= 1'b1;
         end else if (warm_end) begin
            link_warm_reset_reg <= 1'b0;
         end
         warm_cnt_reg <= warm_active ? warm_cnt_reg + 8'h01 :
                         link_warm_reset_reg ? warm_cnt_reg : '0;
      end
   end

   // Returned status, ready state and codec pin capture.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status_fresh_flag_reg <= 1'b0;
         returned_register_value_reg <= '0;
         returned_addr_reg <= '0;
         primary_codec_ready_reg <= 1'b0;
         secondary_codec_ready_reg <= 1'b0;
         slot12_reg <= '0;
      end else begin
         if (status_valid) begin
            status_fresh_flag_reg <= 1'b1;
            returned_register_value_reg <= rx.slot2[RET_DATA_HI:RET_DATA_LO];
            returned_addr_reg <= rx.slot1[RET_ADDR_HI:RET_ADDR_LO];
         end else if (rd_en & hit_status) begin
            status_fresh_flag_reg <= 1'b0;
         end
         if (shut_next) begin
            primary_codec_ready_reg <= 1'b0;
            secondary_codec_ready_reg <= 1'b0;
         end else if (rx_done) begin
            primary_codec_ready_reg <= rx.tag[TAG_FRAME];
            secondary_codec_ready_reg <= rx.tag[TAG_FRAME];
         end
         if (rx_done & rx.tag[TAG_SLOT12]) begin
            slot12_reg <= rx.slot12;
         end
      end
   end

   // Codec pin and wakeup flags, cleared by reading the pin status register.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sdin_d_reg <= 1'b0;
         wakeup_irq_seen_reg <= 1'b0;
         codec_pin_irq_seen_reg <= 1'b0;
         rd_data <= '0;
      end else begin
         sdin_d_reg <= sdin_s;
         wakeup_irq_seen_reg <= wake_event | (wakeup_irq_seen_reg & ~(rd_en & hit_gpio));
         codec_pin_irq_seen_reg <= pin_event | (codec_pin_irq_seen_reg & ~(rd_en & hit_gpio));
         rd_data <= rd_en ? rd_mux : '0;
      end
   end

   a_fresh_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      status_valid |=> status_fresh_flag_reg && returned_register_value_reg ==
         $past(rx.slot2[RET_DATA_HI:RET_DATA_LO]))
      else $error("fresh flag or returned value not captured");
   a_fresh_read_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && hit_status && !status_valid |=> !status_fresh_flag_reg)
      else $error("status read did not clear fresh flag");
   a_cmd_slot_fields: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmd_go |-> tx.slot1[SLOT_W-1] == rw_reg && tx.slot1[18:12] == cmd_addr_reg)
      else $error("slot 1 command fields wrong");
   a_select_tags: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !sel_primary |-> tx.tag[TAG_SLOT1:TAG_SLOT2] == 2'h0 && tx.tag[1:0] == codec_select_reg)
      else $error("slot 0 tags wrong for secondary codec");
   a_shutdown_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ctrl_wr && wr_data[CTL_SHUTDOWN] && !warm_start |=>
         !primary_codec_ready_reg && !secondary_codec_ready_reg)
      else $error("shutdown left codec ready set");
   a_warm_shutdown: assert property (@(posedge clk_sys) disable iff (!rst_n)
      warm_start |=> !link_shutdown_reg && link_warm_reset_reg)
      else $error("warm reset start did not clear shutdown");
   a_warm_sync_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
      warm_start |=> ##1 ac_sync [*8])
      else $error("sync not held high during warm reset");
   a_cmd_sent_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmd_sent && !ctrl_load |=> !cmd_new_reg)
      else $error("command new not cleared after send");
   a_no_new_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ctrl_wr && !wr_data[CTL_NEW] |=> $stable(cmd_data_reg) && $stable(codec_select_reg)
         && $stable(rw_reg) && cmd_new_reg == $past(cmd_new_reg && !cmd_sent))
      else $error("write without new bit changed command");
   a_read_no_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cmd_go && rw_reg |-> tx.slot2 == '0 && !tx.tag[TAG_SLOT2])
      else $error("read command carried slot 2 data");
   a_master_seen: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && hit_master[0] && !master_irq_event[0] |=> !master_irq_seen_reg[0])
      else $error("master status read did not clear seen bit");
   a_master_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      master_irq_event != '0 |=> (master_irq_seen_reg & $past(master_irq_event)) ==
         $past(master_irq_event))
      else $error("master event did not set its seen bit");
   a_wake_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      sdin_s && !sdin_d_reg && link_shutdown_reg |=> wakeup_irq_seen_reg)
      else $error("wakeup edge in power-down not flagged");
   a_pin_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_done && rx.tag[TAG_SLOT12] && rx.slot12[GPIO_EVENT_BIT] |=> codec_pin_irq_seen_reg)
      else $error("codec pin event not flagged");
   a_gpio_read_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_en && hit_gpio && !wake_event && !pin_event |=> !wakeup_irq_seen_reg &&
         !codec_pin_irq_seen_reg)
      else $error("pin status read did not clear flags");
   a_ready_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_done && !shut_next |=> primary_codec_ready_reg == $past(rx.tag[TAG_FRAME]) &&
         secondary_codec_ready_reg == $past(rx.tag[TAG_FRAME]))
      else $error("codec ready does not follow slot 0");
   a_semaphore_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
      ctrl_wr |=> primary_powerdown_semaphore_reg == $past(wr_data[CTL_PRIMARY_POWERDOWN_SEMAPHORE]) &&
         secondary_powerdown_semaphore_reg == $past(wr_data[CTL_SECONDARY_POWERDOWN_SEMAPHORE]))
      else $error("powerdown semaphore not stored");
   a_warm_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      warm_end |=> !link_warm_reset_reg)
      else $error("warm reset bit not cleared after clock resumed");
endmodule

// file: rtl/acl_pkg.sv
// Shared constants, register map and frame carriers for the audio link controller.
package acl_pkg;
   // Register bus widths.
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam int NUM_MASTERS = 8;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0] IDX_GPIO_STATUS = 8'h00;
   localparam logic [7:0] IDX_CODEC_STATUS = 8'h08;
   localparam logic [7:0] IDX_CODEC_CONTROL = 8'h0c;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h12;
   localparam logic [7:0] IDX_ENGINE_CONTROL = 8'h14;
   localparam logic [7:0] IDX_MASTER_STATUS_BASE = 8'h21;
   localparam logic [7:0] IDX_MASTER_STRIDE = 8'h08;
   localparam logic [1:0] BYTE_LANE_ZERO = 2'h0;

   // Codec control word fields.
   localparam int CTL_RW = 31;
   localparam int CTL_ADDR_HI = 30;
   localparam int CTL_ADDR_LO = 24;
   localparam int CTL_SEL_HI = 23;
   localparam int CTL_SEL_LO = 22;
   localparam int CTL_PRIMARY_POWERDOWN_SEMAPHORE = 21;
   localparam int CTL_SECONDARY_POWERDOWN_SEMAPHORE = 20;
   localparam int CTL_SHUTDOWN = 18;
   localparam int CTL_WARM = 17;
   localparam int CTL_NEW = 16;
   localparam int CTL_DATA_HI = 15;
   localparam int CTL_DATA_LO = 0;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

   // Slot field positions.
   localparam int SLOT_W = 20;
   localparam int TAG_W = 16;
   localparam int TAG_FRAME = 15;
   localparam int TAG_SLOT1 = 14;
   localparam int TAG_SLOT2 = 13;
   localparam int TAG_SLOT12 = 3;
   localparam int RET_DATA_HI = 19;
   localparam int RET_DATA_LO = 4;
   localparam int RET_ADDR_HI = 19;
   localparam int RET_ADDR_LO = 12;
   localparam int GPIO_EVENT_BIT = 0;

   // Frame geometry in bit clocks.
   localparam int CNT_W = 8;
   localparam logic [7:0] FRAME_LAST = 8'hff;
   localparam logic [7:0] SYNC_BITS = 8'h10;
   localparam logic [7:0] TX_BITS = 8'h38;
   localparam logic [7:0] SLOT12_FIRST = 8'hec;

   // Warm reset: sync held high with the bit clock stopped.
   localparam int CLK_NS = 10;
   localparam int WARM_NS = 1000;
   localparam int WARM_CYCLES = (WARM_NS + CLK_NS - 1) / CLK_NS;
   localparam int WARM_CNT_W = 8;

   // Outgoing slots 0 to 2.
   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic [SLOT_W-1:0] slot1;
      logic [SLOT_W-1:0] slot2;
   } acl_tx_frame_type;

   // Incoming slots 0 to 2 and slot 12.
   typedef struct packed {
      logic [TAG_W-1:0] tag;
      logic [SLOT_W-1:0] slot1;
      logic [SLOT_W-1:0] slot2;
      logic [SLOT_W-1:0] slot12;
   } acl_rx_frame_type;
endpackage

// file: rtl/acl_sync2.sv
// Two-flop synchroniser for levels arriving from outside the system clock.
`timescale 1ns/10ps
module acl_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;

   // Only the second stage is visible to other logic.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// file: rtl/acl_frame.sv
// Serial frame engine: sync, outgoing slot shifter and incoming slot capture.
`timescale 1ns/10ps
module acl_frame (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic bit_clk_s,
   input wire logic sdin_s,
   input wire logic warm_active,
   input acl_pkg::acl_tx_frame_type tx,
   output logic frame_start,
   output logic bit_rise,
   output logic rx_done,
   output acl_pkg::acl_rx_frame_type rx,
   output logic ac_sync,
   output logic ac_sdata_out
);
   import acl_pkg::*;

   logic bclk_d_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [$bits(acl_tx_frame_type)-1:0] tx_sh_reg;
   logic [$bits(acl_tx_frame_type)-1:0] rx_sh_reg;
   logic [SLOT_W-1:0] s12_sh_reg;
   logic [CNT_W-1:0] cnt_next;
   logic [$bits(acl_tx_frame_type)-1:0] tx_src;
   logic [$bits(acl_tx_frame_type)-1:0] rx_sh_next;
   logic [SLOT_W-1:0] s12_sh_next;
   logic fall;
   logic start;

   // Edge finding on the sampled bit clock; the count is held at FRAME_LAST while warm_active.
   assign bit_rise = bit_clk_s & ~bclk_d_reg;
   assign fall = ~bit_clk_s & bclk_d_reg;
   assign cnt_next = cnt_reg + 8'h01;
   assign start = bit_rise & ~warm_active & (cnt_reg == FRAME_LAST);
   assign frame_start = start;
   assign tx_src = start ? tx : tx_sh_reg;
   assign rx_sh_next = (cnt_reg < TX_BITS) ? {rx_sh_reg[$bits(rx_sh_reg)-2:0], sdin_s} : rx_sh_reg;
   assign s12_sh_next = (cnt_reg >= SLOT12_FIRST) ? {s12_sh_reg[SLOT_W-2:0], sdin_s} : s12_sh_reg;

   // Outgoing side changes on the rising bit clock edge.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bclk_d_reg <= 1'b0;
         cnt_reg <= FRAME_LAST;
         tx_sh_reg <= '0;
         ac_sync <= 1'b0;
         ac_sdata_out <= 1'b0;
      end else begin
         bclk_d_reg <= bit_clk_s;
         if (warm_active) begin
            cnt_reg <= FRAME_LAST;
            ac_sync <= 1'b1;
            ac_sdata_out <= 1'b0;
         end else if (bit_rise) begin
            cnt_reg <= cnt_next;
            ac_sync <= cnt_next < SYNC_BITS;
            ac_sdata_out <= tx_src[$bits(tx_src)-1];
            tx_sh_reg <= {tx_src[$bits(tx_src)-2:0], 1'b0};
         end
      end
   end

   // Incoming side is sampled on the falling bit clock edge.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rx_sh_reg <= '0;
         s12_sh_reg <= '0;
         rx_done <= 1'b0;
         rx <= '0;
      end else begin
         rx_done <= fall & (cnt_reg == FRAME_LAST);
         if (fall) begin
            rx_sh_reg <= rx_sh_next;
            s12_sh_reg <= s12_sh_next;
            if (cnt_reg == FRAME_LAST) begin
               rx <= {rx_sh_next, s12_sh_next};
            end
         end
      end
   end
endmodule

// file: verification/acl_codec_model.sv
// Behavioural codec on the far side of the serial link.
`timescale 1ns/10ps
module acl_codec_model (
   input wire logic run,
   input wire logic wake,
   input wire logic ac_sync,
   input wire logic ac_sdata_out,
   input wire logic [15:0] rx_tag,
   input wire logic [19:0] rx_s1,
   input wire logic [19:0] rx_s2,
   input wire logic [19:0] rx_s12,
   output logic ac_bit_clk,
   output logic ac_sdata_in,
   output logic [55:0] tx_seen
);
   logic [7:0] bit_cnt = 8'hff;
   logic sync_d = 1'b0;
   logic drv = 1'b0;
   logic [55:0] shift = '0;
   logic [255:0] rx_frame;
   initial tx_seen = '0;

   // Return frame: tag, slot 1, slot 2, empty slots 3 to 11, slot 12.
   assign rx_frame = {rx_tag, rx_s1, rx_s2, 180'h0, rx_s12};
   // While powered down the line idles low and only a wake request raises it.
   assign ac_sdata_in = run ? drv : wake;

   // Bit clock of 160 ns that stops low while the codec is powered down.
   initial begin
      ac_bit_clk = 1'b0;
      #3;
      forever begin
         #80;
         ac_bit_clk = run ? ~ac_bit_clk : 1'b0;
      end
   end

   // Outgoing bits are taken on the falling edge; a sync rise marks frame bit 0.
   always @(negedge ac_bit_clk) begin
      if (ac_sync && !sync_d) bit_cnt = 8'h00;
      sync_d = ac_sync;
      if (bit_cnt < 8'h38) shift = {shift[54:0], ac_sdata_out};
      if (bit_cnt == 8'h37) tx_seen = shift;
   end

   // Each return bit is launched on the rising edge, most significant first.
   always @(posedge ac_bit_clk) begin
      bit_cnt = bit_cnt + 8'h01;
      drv = rx_frame[8'hff - bit_cnt];
   end
endmodule

// file: verification/tb.sv
// Self-checking bench for the codec command, status and IRQ status logic.
`timescale 1ns/10ps
module tb;
   import acl_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [DATA_W-1:0] wr_data = '0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [DATA_W-1:0] rd_data;
   logic [NUM_MASTERS-1:0] master_irq_event = '0;
   logic ac_bit_clk;
   logic ac_sdata_in;
   logic ac_sync;
   logic ac_sdata_out;
   logic run = 1'b1;
   logic wake = 1'b0;
   logic [15:0] rx_tag = 16'he008;
   logic [19:0] rx_s12 = 20'h00001;
   logic [55:0] tx_seen;
   logic [31:0] got;
   logic [31:0] cmd = '0;
   logic [1:0] sel;
   logic rw;
   int n_errors = 0;
   int checks = 0;
   int cycles = 0;
   int k;

   acl_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .master_irq_event(master_irq_event),
      .ac_bit_clk(ac_bit_clk), .ac_sdata_in(ac_sdata_in), .ac_sync(ac_sync),
      .ac_sdata_out(ac_sdata_out));
   acl_codec_model i_codec (.run(run), .wake(wake), .ac_sync(ac_sync),
      .ac_sdata_out(ac_sdata_out), .rx_tag(rx_tag), .rx_s1(20'h5a000), .rx_s2(20'hbeef0),
      .rx_s12(rx_s12), .ac_bit_clk(ac_bit_clk), .ac_sdata_in(ac_sdata_in), .tx_seen(tx_seen));

   // System clock of 100 MHz.
   always #5 clk_sys = ~clk_sys;

   // Compares one value and counts the comparison.
   task automatic chk(input string what, input logic [55:0] exp, input logic [55:0] seen);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask

   // One-cycle register read; the data stand in the following cycle only.
   task automatic rd(input logic [9:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 got = rd_data;
   endtask

   task automatic rdc(input logic [9:0] a, input logic [31:0] e);
      rd(a);
      chk($sformatf("register %h", a), {24'h0, e}, {24'h0, got});
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 100000) begin
         n_errors++;
         final_report();
      end
   end

   // Main sequence.
   initial begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(10'h020, 32'h0);
      rdc(10'h030, 32'h0);
      wr(10'h048, 32'hffff);
      rdc(10'h048, 32'h0);
      rdc(10'h3fc, 32'h0);
      wr(10'h050, 32'hffff_ffff);
      rdc(10'h050, 32'h1);
      wr(10'h030, 32'h0030_0000);
      rdc(10'h030, 32'h0030_0000);
      wr(10'h030, 32'hfff0_ffff);
      rdc(10'h030, 32'h0030_0000);
      repeat (4500) @(posedge clk_sys);
      rd(10'h020);
      for (k = 0; k < 300 && got[17] !== 1'b1; k++) rd(10'h020);
      chk("status word", {24'h0, 8'h5a, 2'b11, 6'h02, 16'hbeef}, {24'h0, got});
      rdc(10'h020, {8'h5a, 2'b11, 6'h00, 16'hbeef});
      rdc(10'h048, 32'h1);
      rdc(10'h000, 32'h0020_0001);
      rdc(10'h048, 32'h0);
      rx_tag <= 16'h8000;
      rx_s12 <= 20'h0;
      @(posedge clk_sys);
      master_irq_event <= 8'ha5;
      @(posedge clk_sys);
      master_irq_event <= 8'h00;
      rdc(10'h048, 32'h0294);
      for (int i = 0; i < 8; i++) begin
         rdc(10'h084 + 10'(32 * i), {31'h0, 1'(8'ha5 >> i)});
      end
      rdc(10'h048, 32'h0);
      // Every select code, read and write, through a real frame.
      for (int i = 0; i < 8; i++) begin
         sel = 2'(i >> 1);
         rw = i[0];
         cmd = {rw, 7'h2a + 7'(i), sel, 2'b11, 4'h1, 16'hc3a5 + 16'(i)};
         wr(10'h030, cmd);
         rd(10'h030);
         for (k = 0; k < 3000 && got[16] === 1'b1; k++) rd(10'h030);
         chk("command word", {24'h0, cmd & 32'hfffe_ffff}, {24'h0, got});
         repeat (1200) @(posedge clk_sys);
         chk("frame slots", {1'b1, sel == 2'b00, sel == 2'b00 && !rw, 11'h0, sel,
            rw, 7'h2a + 7'(i), 12'h0, rw ? 20'h0 : {16'hc3a5 + 16'(i), 4'h0}},
            tx_seen & {16'he003, 40'hff_ffff_ffff});
         if (i == 0) rd(10'h020);
      end
      rdc(10'h020, {8'h5a, 2'b11, 6'h00, 16'hbeef});
      // Shutdown, wakeup and warm reset with the bit clock stopped.
      @(posedge clk_sys);
      run <= 1'b0;
      repeat (20) @(posedge clk_sys);
      wr(10'h030, 32'h0034_0000);
      rdc(10'h020, {8'h5a, 2'b00, 6'h00, 16'hbeef});
      @(posedge clk_sys);
      wake <= 1'b1;
      repeat (10) @(posedge clk_sys);
      rdc(10'h048, 32'h2);
      rdc(10'h000, 32'h0010_0000);
      rdc(10'h048, 32'h0);
      wake <= 1'b0;
      rd(10'h030);
      wr(10'h030, got | 32'h0002_0000);
      rdc(10'h030, (cmd & 32'hffc0_ffff) | 32'h0032_0000);
      repeat (150) @(posedge clk_sys);
      run <= 1'b1;
      rd(10'h030);
      for (k = 0; k < 200 && got[17] === 1'b1; k++) rd(10'h030);
      chk("warm done", {24'h0, (cmd & 32'hffc0_ffff) | 32'h0030_0000}, {24'h0, got});
      repeat (9000) @(posedge clk_sys);
      rdc(10'h020, {8'h5a, 2'b11, 6'h00, 16'hbeef});
      // After a power cycle software lifts the shutdown itself.
      wr(10'h030, 32'h0034_0000);
      wr(10'h030, 32'h0030_0000);
      rdc(10'h030, (cmd & 32'hffc0_ffff) | 32'h0030_0000);
      final_report();
   end
endmodule
